// *** bench/urs_far_model.sv ***
// far-side model: remote sender feeding the receiver, remote sink of the transmitter
`default_nettype none
module urs_far_model (
  input  wire logic               core_clk,
  output var logic                rx_start,
  output var logic                rx_done,
  output var urs_pkg::urs_rx_in_t rx_char,
  output var logic                tx_req,
  output var logic                tx_fc_start,
  output var logic                tx_stop_done,
  input  wire logic [7:0]         tx_data,
  input  wire logic               tx_data_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_start     = 1'b0;
    rx_done      = 1'b0;
    rx_char      = '0;
    tx_req       = 1'b0;
    tx_fc_start  = 1'b0;
    tx_stop_done = 1'b0;
  end
  // ----------------------------------------
  // receive side
  // ----------------------------------------
  task automatic start_bit();
    @(posedge core_clk);
    rx_start <= 1'b1;
    @(posedge core_clk);
    rx_start <= 1'b0;
  endtask
  // rx_char is only valid with rx_done, so it is scrambled afterwards
  task automatic send_char(input urs_pkg::urs_rx_in_t c);
    start_bit();
    repeat (3) @(posedge core_clk);
    rx_done <= 1'b1;
    rx_char <= c;
    @(posedge core_clk);
    rx_done <= 1'b0;
    rx_char <= ~c;
  endtask
  // ----------------------------------------
  // transmit side
  // ----------------------------------------
  // last stop bit sent
  task automatic stop_bit();
    @(posedge core_clk);
    tx_stop_done <= 1'b1;
    @(posedge core_clk);
    tx_stop_done <= 1'b0;
  endtask
  task automatic fc_begin();
    @(posedge core_clk);
    tx_fc_start <= 1'b1;
    @(posedge core_clk);
    tx_fc_start <= 1'b0;
  endtask
  // a slow line is modelled by the stall between accept and stop bit
  task automatic tx_one(input int stall, output logic [7:0] d, output bit ok);
    @(posedge core_clk);
    tx_req <= 1'b1;
    @(posedge core_clk);
    tx_req <= 1'b0;
    ok = 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      if (tx_data_valid === 1'b1) begin
        ok = 1'b1;
        d  = tx_data;
        break;
      end
    end
    repeat (stall) @(posedge core_clk);
    stop_bit();
  endtask
endmodule
`default_nettype wire

// *** bench/urs_status_test.sv ***
// self-checking testbench of the uart status block
`default_nettype none
module urs_status_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RXD = 4;
  logic                core_clk;
  logic                resetn;
  logic [2:0]          avs_address;
  logic                avs_read, avs_write, avs_waitrequest;
  logic [31:0]         avs_writedata, avs_readdata;
  logic [3:0]          avs_byteenable;
  logic                rx_start, rx_done, tx_req, tx_fc_start, tx_stop_done;
  urs_pkg::urs_rx_in_t rx_char;
  logic [7:0]          tx_data;
  logic                tx_data_valid, tx_enable, overrun, tx_idle, irq;
  int                  n_mismatch = 0;
  int                  checks_done = 0;
  int                  rxq[$];
  urs_status #(.RX_DEPTH(RXD), .TX_DEPTH(4)) dut (.core_clk(core_clk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_start(rx_start),
    .rx_done(rx_done), .rx_char(rx_char), .tx_req(tx_req), .tx_fc_start(tx_fc_start),
    .tx_stop_done(tx_stop_done), .tx_data(tx_data), .tx_data_valid(tx_data_valid),
    .tx_enable(tx_enable), .overrun(overrun), .tx_idle(tx_idle), .irq(irq));
  urs_far_model far (.core_clk(core_clk), .rx_start(rx_start), .rx_done(rx_done),
    .rx_char(rx_char), .tx_req(tx_req), .tx_fc_start(tx_fc_start),
    .tx_stop_done(tx_stop_done), .tx_data(tx_data), .tx_data_valid(tx_data_valid));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int i;
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_write     <= wr;
    avs_read      <= ~wr;
    for (i = 0; i < 16; i++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (i == 16) begin
      n_mismatch++;
      $display("MISMATCH %0t bus answer missing", $time);
      close_out();
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    logic [31:0] t;
    bus(1'b1, a, d, t);
  endtask
  task automatic rd(input logic [2:0] a, output logic [31:0] d);
    bus(1'b0, a, 32'h0, d);
  endtask
  task automatic settle();
    repeat (2) @(posedge core_clk);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    n_mismatch++;
    close_out();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0]         d;
    urs_pkg::urs_rx_in_t c;
    logic                f;
    logic [7:0]          td, tv;
    bit                  ok;
    resetn         = 1'b0;
    avs_address    = 3'h0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0;
    avs_byteenable = 4'hF;
    void'($urandom(32'h08C7));
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    rd(urs_pkg::REG_STAT, d);
    chk(d, 32'h4); // status after reset
    chk({overrun, tx_idle, irq}, 3'h0); // flags after reset
    wr(3'h7, 32'hFF);
    rd(3'h7, d);
    chk(d, 32'h0);
    $display("reset test done");
    for (int m = 0; m < 4; m++) begin
      for (int odd = 0; odd < 2; odd++) begin
        wr(urs_pkg::REG_CTRL, 32'(m + 4 * odd));
        c = urs_pkg::urs_rx_in_t'($urandom);
        far.send_char(c);
        f = (m == 1) ? (c.par_bit ^ (^c.data) ^ odd[0]) :
            (m == 2) ? (c.par_bit ^ odd[0]) : (m == 3) ? c.par_bit : 1'b0;
        settle();
        rd(urs_pkg::REG_STAT, d);
        chk(d, {26'h0, f, 5'h5}); // head flag
        rd(urs_pkg::REG_DATA, d);
        chk(d, {21'h0, c.frm, c.brk, f, c.data}); // entry with its flag
      end
    end
    chk(irq, 1'b0);
    rd(urs_pkg::REG_IST, d);
    chk(d, 32'h4);
    wr(urs_pkg::REG_IST, 32'h4);
    rd(urs_pkg::REG_IST, d);
    chk(d, 32'h0);
    $display("parity test done");
    wr(urs_pkg::REG_CTRL, 32'h0);
    wr(urs_pkg::REG_IMASK, 32'h1);
    for (int i = 0; i < RXD + 1; i++) begin
      c = urs_pkg::urs_rx_in_t'({8'($urandom), 3'h0});
      far.send_char(c);
      rxq.push_back(int'(c.data));
    end
    settle();
    rd(urs_pkg::REG_STAT, d);
    chk(d, 32'h7); // full without overrun
    rd(urs_pkg::REG_DATA, d);
    chk(d, 32'(rxq.pop_front())); // oldest first
    rd(urs_pkg::REG_STAT, d);
    chk(d, 32'h7); // held character moved in
    c = urs_pkg::urs_rx_in_t'({8'($urandom), 3'h7});
    far.send_char(c);
    far.start_bit();
    settle();
    chk({overrun, irq}, 2'h3); // overrun raised
    rd(urs_pkg::REG_STAT, d);
    chk(d, 32'h17); // queue kept
    for (int i = 0; i < RXD; i++) begin
      rd(urs_pkg::REG_DATA, d);
      chk(d, 32'(rxq.pop_front())); // queued characters kept
    end
    rd(urs_pkg::REG_DATA, d);
    chk(d, 32'h0); // held character dropped
    rd(urs_pkg::REG_STAT, d);
    chk(d, 32'h14); // overrun stays after reads
    wr(urs_pkg::REG_CMD, 32'h1);
    wr(urs_pkg::REG_IST, 32'h1);
    settle();
    chk({overrun, irq}, 2'h0); // overrun cleared by command, irq by status write
    $display("overrun test done");
    wr(urs_pkg::REG_CTRL, 32'h8);
    settle();
    chk(tx_enable, 1'b1);
    td = 8'($urandom);
    wr(urs_pkg::REG_DATA, {24'h0, td});
    wr(urs_pkg::REG_DATA, {24'h0, ~td});
    far.tx_one(1, tv, ok);
    chk({ok, tv}, {1'b1, td});
    settle();
    chk(tx_idle, 1'b0); // queue not empty yet
    far.tx_one(3, tv, ok);
    chk({ok, tv}, {1'b1, ~td});
    settle();
    chk(tx_idle, 1'b1); // underrun after last stop bit
    rd(urs_pkg::REG_STAT, d);
    chk(d, 32'hC); // idle in status
    wr(urs_pkg::REG_DATA, 32'h5A);
    settle();
    chk(tx_idle, 1'b0); // cleared by load
    far.tx_one(0, tv, ok);
    settle();
    chk(tx_idle, 1'b1); // set again
    far.fc_begin();
    settle();
    chk(tx_idle, 1'b0); // zero during flow-control send
    far.stop_bit();
    settle();
    chk(tx_idle, 1'b1);
    far.fc_begin();
    wr(urs_pkg::REG_DATA, 32'hC3);
    far.stop_bit();
    settle();
    chk(tx_idle, 1'b0); // load during flow-control send
    far.tx_one(0, tv, ok);
    chk({ok, tv}, 9'h1C3);
    settle();
    wr(urs_pkg::REG_CTRL, 32'h0);
    settle();
    chk(tx_idle, 1'b0); // cleared by disable
    wr(urs_pkg::REG_CTRL, 32'h8);
    far.stop_bit();
    settle();
    chk(tx_idle, 1'b1);
    wr(urs_pkg::REG_CMD, 32'h2);
    settle();
    chk(tx_idle, 1'b0); // cleared by transmitter reset
    $display("idle test done");
    wr(urs_pkg::REG_DATA, 32'h11);
    far.send_char(urs_pkg::urs_rx_in_t'(11'h155));
    @(posedge core_clk);
    resetn <= 1'b0;
    settle();
    resetn <= 1'b1;
    rd(urs_pkg::REG_STAT, d);
    chk(d, 32'h4); // receive queue emptied
    rd(urs_pkg::REG_DATA, d);
    chk(d, 32'h0); // nothing left to read
    wr(urs_pkg::REG_CTRL, 32'h8);
    far.tx_one(0, tv, ok);
    chk(ok, 1'b0); // transmit queue emptied
    $display("second reset test done");
    close_out();
  end
endmodule
`default_nettype wire

// *** common/urs_pkg.sv ***
// package: register map, fields, carriers and parity check of the uart status block
`default_nettype none
package urs_pkg;
  // ----------------------------------------
  // register word indices
  // ----------------------------------------
  localparam logic [2:0] REG_CTRL  = 3'h0;
  localparam logic [2:0] REG_STAT  = 3'h1;
  localparam logic [2:0] REG_CMD   = 3'h2;
  localparam logic [2:0] REG_DATA  = 3'h3;
  localparam logic [2:0] REG_IST   = 3'h4;
  localparam logic [2:0] REG_IMASK = 3'h5;
  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int unsigned CHAR_W      = 8;
  localparam int unsigned CTRL_MODE_L = 0;
  localparam int unsigned CTRL_MODE_W = 2;
  localparam int unsigned CTRL_ODD    = 2;
  localparam int unsigned CTRL_TXEN   = 3;
  localparam int unsigned CMD_RERR    = 0;
  localparam int unsigned CMD_RTX     = 1;
  localparam int unsigned ST_RXRDY    = 0;
  localparam int unsigned ST_RXFULL   = 1;
  localparam int unsigned ST_TXRDY    = 2;
  localparam int unsigned ST_IDLE     = 3;
  localparam int unsigned ST_OVR      = 4;
  localparam int unsigned ST_PAR      = 5;
  localparam int unsigned IRQ_OVR     = 0;
  localparam int unsigned IRQ_IDLE    = 1;
  localparam int unsigned IRQ_RX      = 2;
  localparam int unsigned IRQ_W       = 3;
  localparam logic [IRQ_W-1:0] IMASK_RESET = 3'h0;
  localparam int unsigned QUEUE_DEPTH = 256;

  typedef enum logic [1:0] {
    PAR_NONE  = 2'b00,
    PAR_WITH  = 2'b01,
    PAR_FORCE = 2'b10,
    PAR_WAKE  = 2'b11
  } urs_par_mode_t;

  typedef struct packed {
    logic [CHAR_W-1:0] data;
    logic              par_bit;
    logic              brk;
    logic              frm;
  } urs_rx_in_t;

  // queue entry, laid out as the data register reads it
  typedef struct packed {
    logic              frm;
    logic              brk;
    logic              par_flag;
    logic [CHAR_W-1:0] data;
  } urs_rx_ent_t;

  // per-character flag: parity mismatch, or the address marker in wake-up mode
  function automatic logic urs_par_flag(urs_par_mode_t m, logic odd, urs_rx_in_t c);
    case (m)
      PAR_WITH:  return c.par_bit != ((^c.data) ^ odd);
      PAR_FORCE: return c.par_bit != odd;
      PAR_WAKE:  return c.par_bit;
      default:   return 1'b0;
    endcase
  endfunction
endpackage
`default_nettype wire

// *** hdl/urs_queue.sv ***
// flip-flop queue with flush, simultaneous push and pop allowed
`default_nettype none
module urs_queue #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 256
) (
  input  wire logic         core_clk,
  input  wire logic         resetn,
  input  wire logic         flush,
  input  wire logic         push,
  input  wire logic [W-1:0] wdata,
  input  wire logic         pop,
  output logic [W-1:0]      head,
  output logic              full,
  output logic              empty
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          do_push;
  logic          do_pop;

  function automatic logic [AW-1:0] nxt(logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  assign full    = cnt_q == (AW+1)'(DEPTH);
  assign empty   = cnt_q == '0;
  assign head    = mem_q[rp_q];
  assign do_pop  = pop & ~empty;
  assign do_push = push & (~full | do_pop);

  always_ff @(posedge core_clk) begin
    if (!resetn || flush) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= '0;
    end else begin
      if (do_push) begin
        mem_q[wp_q] <= wdata;
        wp_q        <= nxt(wp_q);
      end
      if (do_pop) rp_q <= nxt(rp_q);
      if (do_push && !do_pop) cnt_q <= cnt_q + (AW+1)'(1);
      else if (do_pop && !do_push) cnt_q <= cnt_q - (AW+1)'(1);
    end
  end
endmodule
`default_nettype wire

// *** hdl/urs_status.sv ***
// uart receive error, overrun and transmitter idle status with register slave
// Operation
// R1: flag parity mismatch on each queued character
// R2: wake-up mode stores address marker instead
// R3: start bit with 257 pending sets overrun
// R4: overrun drops held character and its status
// R5: overrun stays until reset-error command
// R6: idle set after stop bit, queue empty
// R7: load, disable or transmitter reset clear idle
// R8: flow-control send keeps idle at zero
// R9: load during flow-control send drops idle
// R10: held character enters queue on read
// R11: reset clears flags and both queues
`default_nettype none
module urs_status #(
  parameter int unsigned RX_DEPTH = urs_pkg::QUEUE_DEPTH,
  parameter int unsigned TX_DEPTH = urs_pkg::QUEUE_DEPTH
) (
  input  wire logic                core_clk,
  input  wire logic                resetn,
  input  wire logic [2:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest,
  input  wire logic                rx_start,
  input  wire logic                rx_done,
  input  wire urs_pkg::urs_rx_in_t rx_char,
  input  wire logic                tx_req,
  input  wire logic                tx_fc_start,
  input  wire logic                tx_stop_done,
  output logic [7:0]               tx_data,
  output logic                     tx_data_valid,
  output logic                     tx_enable,
  output logic                     overrun,
  output logic                     tx_idle,
  output logic                     irq
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic                   wait_q;
  logic                   ack;
  logic [31:0]            rdata_q;
  logic [31:0]            rd_d;
  urs_pkg::urs_par_mode_t mode_q;
  logic                   odd_q;
  logic                   txen_q;
  logic                   ovr_q;
  logic                   ovr_evt;
  logic [urs_pkg::IRQ_W-1:0] ist_q;
  logic [urs_pkg::IRQ_W-1:0] imask_q;
  logic [urs_pkg::IRQ_W-1:0] evt;
  logic                   irq_q;
  urs_pkg::urs_rx_ent_t   hold_q;
  logic                   hold_v_q;
  urs_pkg::urs_rx_ent_t   new_ent;
  urs_pkg::urs_rx_ent_t   rxq_wdata;
  urs_pkg::urs_rx_ent_t   rxq_head;
  logic                   rxq_push;
  logic                   rxq_full;
  logic                   rxq_empty;
  logic                   rx_pop;
  logic [7:0]             txq_head;
  logic                   txq_full;
  logic                   txq_empty;
  logic                   tx_load;
  logic                   tx_pop;
  logic [7:0]             txd_q;
  logic                   txv_q;
  logic                   idle;
  logic                   idle_prev_q;
  logic                   wr_acc;
  logic                   cmd_wr;
  logic                   cmd_rerr;
  logic                   cmd_rtx;
  logic                   pop_ok_q;

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  // one wait cycle, then a single answer cycle; effects land on the answer edge
  assign ack      = ~wait_q;
  assign wr_acc   = ack & avs_write & avs_byteenable[0];
  assign cmd_wr   = wr_acc & (avs_address == urs_pkg::REG_CMD);
  assign cmd_rerr = cmd_wr & avs_writedata[urs_pkg::CMD_RERR];
  assign cmd_rtx  = cmd_wr & avs_writedata[urs_pkg::CMD_RTX];
  assign tx_load  = wr_acc & (avs_address == urs_pkg::REG_DATA) & ~txq_full;
  assign rx_pop   = ack & avs_read & pop_ok_q;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~((avs_read | avs_write) & wait_q);
    end
  end

  always_comb begin
    rd_d = '0;
    case (avs_address)
      urs_pkg::REG_CTRL: begin
        rd_d[urs_pkg::CTRL_MODE_L +: urs_pkg::CTRL_MODE_W] = mode_q;
        rd_d[urs_pkg::CTRL_ODD]  = odd_q;
        rd_d[urs_pkg::CTRL_TXEN] = txen_q;
      end
      urs_pkg::REG_STAT: begin
        rd_d[urs_pkg::ST_RXRDY]  = ~rxq_empty;
        rd_d[urs_pkg::ST_RXFULL] = rxq_full;
        rd_d[urs_pkg::ST_TXRDY]  = ~txq_full;
        rd_d[urs_pkg::ST_IDLE]   = idle;
        rd_d[urs_pkg::ST_OVR]    = ovr_q;
        rd_d[urs_pkg::ST_PAR]    = ~rxq_empty & rxq_head.par_flag;
      end
      urs_pkg::REG_DATA: begin
        if (!rxq_empty) rd_d[$bits(rxq_head)-1:0] = rxq_head;
      end
      urs_pkg::REG_IST:   rd_d[urs_pkg::IRQ_W-1:0] = ist_q;
      urs_pkg::REG_IMASK: rd_d[urs_pkg::IRQ_W-1:0] = imask_q;
      default:            rd_d = '0;
    endcase
  end

  // read data is caught on the edge that lowers waitrequest
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rdata_q <= '0;
    end else if (avs_read && wait_q) begin
      rdata_q <= rd_d;
    end
  end

  // pop only after a read that captured a character: a push landing between
  // capture and answer would otherwise be popped unseen
  always_ff @(posedge core_clk) begin
    if (!resetn) pop_ok_q <= 1'b0;
    else pop_ok_q <= avs_read & wait_q & (avs_address == urs_pkg::REG_DATA) & ~rxq_empty;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mode_q <= urs_pkg::PAR_NONE;
      odd_q  <= 1'b0;
      txen_q <= 1'b0;
    end else if (wr_acc && avs_address == urs_pkg::REG_CTRL) begin
      mode_q <= urs_pkg::urs_par_mode_t'(
                avs_writedata[urs_pkg::CTRL_MODE_L +: urs_pkg::CTRL_MODE_W]);
      odd_q  <= avs_writedata[urs_pkg::CTRL_ODD];
      txen_q <= avs_writedata[urs_pkg::CTRL_TXEN];
    end
  end

  // ----------------------------------------
  // receive path
  // ----------------------------------------
  always_comb begin
    new_ent.data = rx_char.data;
    new_ent.brk  = rx_char.brk;
    new_ent.frm  = rx_char.frm;
    // R1 R2: parity or marker flag
    new_ent.par_flag = urs_pkg::urs_par_flag(mode_q, odd_q, rx_char);
  end

  // R3: 257 pending and a new start bit
  assign ovr_evt = rx_start & rxq_full & hold_v_q & ~rx_pop;

  always_comb begin
    rxq_push  = 1'b0;
    rxq_wdata = new_ent;
    // R10: held character first
    if (hold_v_q && rx_pop) begin
      rxq_push  = 1'b1;
      rxq_wdata = hold_q;
    end else if (rx_done && !hold_v_q && (!rxq_full || rx_pop)) begin
      rxq_push = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      hold_v_q <= 1'b0;
      hold_q   <= '0;
    // R4: held character lost with its status
    end else if (ovr_evt) begin
      hold_v_q <= 1'b0;
      hold_q   <= '0;
    end else if (hold_v_q && rx_pop) begin
      hold_v_q <= rx_done;
      hold_q   <= new_ent;
    end else if (rx_done && rxq_full && !rx_pop) begin
      hold_v_q <= 1'b1;
      hold_q   <= new_ent;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ovr_q <= 1'b0;
    // R3 R5: set wins over the clearing command
    end else if (ovr_evt) begin
      ovr_q <= 1'b1;
    end else if (cmd_rerr) begin
      ovr_q <= 1'b0;
    end
  end

  // R11: reset empties the queue
  urs_queue #(
    .W     ($bits(urs_pkg::urs_rx_ent_t)),
    .DEPTH (RX_DEPTH)
  ) u_rxq (
    .core_clk (core_clk),
    .resetn   (resetn),
    .flush    (1'b0),
    .push     (rxq_push),
    .wdata    (rxq_wdata),
    .pop      (rx_pop),
    .head     (rxq_head),
    .full     (rxq_full),
    .empty    (rxq_empty)
  );

  // ----------------------------------------
  // transmit path
  // ----------------------------------------
  // characters loaded while disabled wait in the queue
  assign tx_pop = tx_req & txen_q & ~txq_empty;

  urs_queue #(
    .W     (urs_pkg::CHAR_W),
    .DEPTH (TX_DEPTH)
  ) u_txq (
    .core_clk (core_clk),
    .resetn   (resetn),
    .flush    (cmd_rtx),
    .push     (tx_load),
    .wdata    (avs_writedata[urs_pkg::CHAR_W-1:0]),
    .pop      (tx_pop),
    .head     (txq_head),
    .full     (txq_full),
    .empty    (txq_empty)
  );

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      txd_q <= '0;
      txv_q <= 1'b0;
    end else begin
      txv_q <= tx_pop;
      if (tx_pop) txd_q <= txq_head;
    end
  end

  urs_tx_idle u_idle (
    .core_clk    (core_clk),
    .resetn      (resetn),
    .tx_enable   (txen_q),
    .tx_reset    (cmd_rtx),
    .cpu_load    (tx_load),
    .fc_start    (tx_fc_start),
    .stop_done   (tx_stop_done),
    .queue_empty (txq_empty),
    .idle_q      (idle)
  );

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  always_comb begin
    evt                    = '0;
    evt[urs_pkg::IRQ_OVR]  = ovr_evt;
    evt[urs_pkg::IRQ_IDLE] = idle & ~idle_prev_q;
    evt[urs_pkg::IRQ_RX]   = rxq_push;
  end

  // a new event outranks a write-one-to-clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ist_q       <= '0;
      imask_q     <= urs_pkg::IMASK_RESET;
      idle_prev_q <= 1'b0;
      irq_q       <= 1'b0;
    end else begin
      idle_prev_q <= idle;
      irq_q       <= |(ist_q & imask_q);
      if (wr_acc && avs_address == urs_pkg::REG_IST)
        ist_q <= (ist_q & ~avs_writedata[urs_pkg::IRQ_W-1:0]) | evt;
      else
        ist_q <= ist_q | evt;
      if (wr_acc && avs_address == urs_pkg::REG_IMASK)
        imask_q <= avs_writedata[urs_pkg::IRQ_W-1:0];
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata    = rdata_q;
  assign tx_data         = txd_q;
  assign tx_data_valid   = txv_q;
  assign tx_enable       = txen_q;
  assign overrun         = ovr_q;
  assign tx_idle         = idle;
  assign irq             = irq_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_ovr;
    rx_start && rxq_full && hold_v_q && !rx_pop;
  endsequence

  property p_par_check;
    (mode_q == urs_pkg::PAR_WITH || mode_q == urs_pkg::PAR_FORCE)
      && rx_done && rxq_empty && !hold_v_q
    |=> rxq_head.par_flag == ($past(rx_char.par_bit) ^ $past(odd_q)
        ^ ($past(mode_q) == urs_pkg::PAR_WITH && $past(^rx_char.data)));
  endproperty
  a_par_check: assert property (p_par_check) else $error("parity flag wrong"); // R1

  property p_wake_marker;
    mode_q == urs_pkg::PAR_WAKE && rx_done && rxq_empty && !hold_v_q
    |=> rxq_head.par_flag == $past(rx_char.par_bit);
  endproperty
  a_wake_marker: assert property (p_wake_marker) else $error("marker not stored"); // R2

  property p_ovr_set;
    s_ovr |=> ovr_q && ist_q[urs_pkg::IRQ_OVR];
  endproperty
  a_ovr_set: assert property (p_ovr_set) else $error("overrun not flagged"); // R3

  property p_ovr_drop;
    s_ovr |=> !hold_v_q && rxq_full;
  endproperty
  a_ovr_drop: assert property (p_ovr_drop) else $error("overrun kept held char"); // R4

  property p_ovr_hold;
    ovr_q && !cmd_rerr |=> ovr_q;
  endproperty
  a_ovr_hold: assert property (p_ovr_hold) else $error("overrun dropped early"); // R5

  property p_hold_move;
    hold_v_q && rx_pop && !rx_done |=> !hold_v_q && rxq_full;
  endproperty
  a_hold_move: assert property (p_hold_move) else $error("held char not moved"); // R10

  property p_reset_clear;
    disable iff (1'b0) !resetn |=> !ovr_q && rxq_empty && txq_empty && !hold_v_q;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left state"); // R11

  property p_irq_level;
    1'b1 |=> irq_q == $past(|(ist_q & imask_q));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq not raised");
endmodule
`default_nettype wire

// *** hdl/urs_tx_idle.sv ***
// transmitter underrun (idle) flag
`default_nettype none
module urs_tx_idle (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic tx_enable,
  input  wire logic tx_reset,
  input  wire logic cpu_load,
  input  wire logic fc_start,
  input  wire logic stop_done,
  input  wire logic queue_empty,
  output logic      idle_q
);
  // clears win: a load in the stop-bit cycle means a character is waiting
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      idle_q <= 1'b0;
    // R7 R8 R9: clear conditions
    end else if (!tx_enable || tx_reset || cpu_load || fc_start) begin
      idle_q <= 1'b0;
    // R6: set after last stop bit
    end else if (stop_done && queue_empty) begin
      idle_q <= 1'b1;
    end
  end

  sequence s_fc_load;
    idle_q && fc_start ##[1:4] cpu_load;
  endsequence

  property p_idle_set;
    @(posedge core_clk) disable iff (!resetn)
    stop_done && queue_empty && tx_enable && !tx_reset && !cpu_load && !fc_start |=> idle_q;
  endproperty
  a_idle_set: assert property (p_idle_set) else $error("idle not set after stop bit"); // R6

  property p_idle_clr;
    @(posedge core_clk) disable iff (!resetn)
    cpu_load || !tx_enable || tx_reset |=> !idle_q;
  endproperty
  a_idle_clr: assert property (p_idle_clr) else $error("idle not cleared"); // R7

  property p_idle_fc;
    @(posedge core_clk) disable iff (!resetn)
    idle_q && fc_start |=> !idle_q;
  endproperty
  a_idle_fc: assert property (p_idle_fc) else $error("idle high in flow send"); // R8

  property p_idle_fc_load;
    @(posedge core_clk) disable iff (!resetn)
    s_fc_load |=> !idle_q;
  endproperty
  a_idle_fc_load: assert property (p_idle_fc_load) else $error("idle high after load"); // R9
endmodule
`default_nettype wire
